/* pkg/esc_pkg.sv */
// Constants, instruction classes and cycle tables for the execution state counter.
// Assumes one 25 MHz CPU system clock; one state is one clock period.
// Overview of operation
// - States equal weighted sum of cycle classes.
// - On-chip memory fetch cycle takes two states.
// - Peripheral byte access takes two or three.
// - Long immediate add/AND: three fetches only.
// - Word immediate two fetches; word register one.
// - Listed short forms take one fetch cycle.
// - Memory bit-AND: two fetches, one byte access.
// - Short branches take two fetches, taken or not.
package esc_pkg;

   localparam int CLK_PERIOD_NS = 40;

   // Per-cycle state costs.
   localparam logic [1:0] S_FETCH_MEM       = 2'h2;
   localparam logic [1:0] S_BRANCH_ADDR     = 2'h2;
   localparam logic [1:0] S_STACK           = 2'h2;
   localparam logic [1:0] S_BYTE_MEM        = 2'h2;
   localparam logic [1:0] S_BYTE_PERIPH_LO  = 2'h2;
   localparam logic [1:0] S_BYTE_PERIPH_HI  = 2'h3;
   localparam logic [1:0] S_WORD_MEM        = 2'h2;
   localparam logic [1:0] S_INTERNAL        = 2'h1;

   localparam int         INSTR_W   = 5;
   localparam int         TOTAL_W   = 4;
   localparam logic [1:0] FETCH_ONE = 2'h1;
   localparam logic [1:0] FETCH_TWO = 2'h2;
   localparam logic [1:0] FETCH_TRI = 2'h3;

   typedef enum logic [INSTR_W-1:0] {
      ESC_ADD_B_IMM, ESC_ADD_B_REG, ESC_ADD_W_IMM, ESC_ADD_W_REG,
      ESC_ADD_L_IMM, ESC_ADD_L_REG, ESC_ADDRESS_INCREMENT_ADD,
      ESC_ADD_WITH_CARRY_IMM, ESC_ADD_WITH_CARRY_REG,
      ESC_AND_B_IMM, ESC_AND_B_REG, ESC_AND_W_IMM, ESC_AND_W_REG,
      ESC_AND_L_IMM, ESC_AND_L_REG, ESC_AND_INTO_CONDITION_CODES,
      ESC_BIT_AND_REG, ESC_BIT_AND_INDIRECT, ESC_BIT_AND_ABS8, ESC_BRANCH_D8
   } esc_instr_t;

   typedef enum logic [1:0] {ESC_IDLE, ESC_FETCH, ESC_DATA} esc_phase_t;

   // Fetch cycles per instruction; zero marks a code outside the table.
   function automatic logic [1:0] esc_fetch_count(input logic [INSTR_W-1:0] code);
      logic [1:0] n;
      n = 2'h0;
      unique case (code)
         ESC_ADD_L_IMM, ESC_AND_L_IMM:                      n = FETCH_TRI;
         ESC_ADD_W_IMM, ESC_AND_W_IMM:                      n = FETCH_TWO;
         ESC_ADD_W_REG, ESC_AND_W_REG:                      n = FETCH_ONE;
         ESC_AND_L_REG:                                     n = FETCH_TWO;
         ESC_ADD_L_REG:                                     n = FETCH_ONE;
         ESC_ADD_B_IMM, ESC_ADD_B_REG, ESC_ADDRESS_INCREMENT_ADD,
         ESC_ADD_WITH_CARRY_IMM, ESC_ADD_WITH_CARRY_REG, ESC_AND_B_IMM,
         ESC_AND_B_REG, ESC_AND_INTO_CONDITION_CODES, ESC_BIT_AND_REG: n = FETCH_ONE;
         ESC_BIT_AND_INDIRECT, ESC_BIT_AND_ABS8:            n = FETCH_TWO;
         ESC_BRANCH_D8:                                     n = FETCH_TWO;
         default:                                           n = 2'h0;
      endcase
      return n;
   endfunction

   // Byte data access cycles per instruction.
   function automatic logic esc_byte_count(input logic [INSTR_W-1:0] code);
      return (code == ESC_BIT_AND_INDIRECT) || (code == ESC_BIT_AND_ABS8);
   endfunction

endpackage

/* rtl/esc_cycle_timer.sv */
// Down counter that measures the states of one bus cycle.
// Assumes the owner loads a non-zero length at every cycle start.
`timescale 1ns/1ns
module esc_cycle_timer #(
   parameter int W = 2
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         load,
   input  wire logic [W-1:0] len,
   output logic [W-1:0]      left,
   output logic              last
);
   typedef struct packed {
      logic [W-1:0] left;
   } esc_timer_t;

   esc_timer_t st, next_st;

   always_comb begin
      next_st = st;
      if (load) begin
         next_st.left = len;
      end else if (st.left != '0) begin
         next_st.left = st.left - W'(1);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign left = st.left;
   assign last = (st.left == W'(1));
endmodule

/* rtl/esc_state_counter.sv */
// Execution state counter: times one instruction as a sequence of bus cycles.
// Assumes the decoder issues one pulse per instruction only while busy is low.
`timescale 1ns/1ns
module esc_state_counter
   import esc_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               resetn,
   input  wire logic               issue,
   input  wire logic [INSTR_W-1:0] instr_code,
   input  wire logic               byte_to_periph,
   input  wire logic               periph_slow,
   output logic                    busy,
   output logic                    cpu_wait,
   output logic                    done,
   output logic                    illegal,
   output logic [TOTAL_W-1:0]      total_states
);
   // All counting state except the bus-cycle timer's count lives in one record, so reset clears every field in one place.
   // The outputs are fields of this record and therefore come straight from flip-flops.
   typedef struct packed {
      esc_phase_t         phase;
      logic [1:0]         fetch_left;
      logic               byte_left;
      logic [1:0]         byte_cost;
      logic [TOTAL_W-1:0] elapsed;
      logic [TOTAL_W-1:0] total;
      logic               busy;
      logic               cpu_wait;
      logic               done;
      logic               illegal;
   } esc_state_t;

   esc_state_t st, next_st;
   logic       t_load;
   logic [1:0] t_len;
   logic [1:0] t_left;
   logic       t_last;
   logic [1:0] n_fetch;
   logic       n_byte;
   logic [1:0] n_cost;

   // One timer serves fetch and data cycles alike, since only one bus cycle runs at a time.
   // Its two-bit length limits a single bus cycle to three states.
   esc_cycle_timer #(.W(2)) u_timer (
      .clk    (clk),
      .resetn (resetn),
      .load   (t_load),
      .len    (t_len),
      .left   (t_left),
      .last   (t_last)
   );

   always_comb begin
      next_st          = st;
      next_st.done     = 1'b0;
      next_st.illegal  = 1'b0;
      next_st.cpu_wait = 1'b0;
      t_load           = 1'b0;
      t_len            = S_FETCH_MEM;
      n_fetch          = esc_fetch_count(instr_code);
      n_byte           = esc_byte_count(instr_code);
      n_cost           = byte_to_periph ? (periph_slow ? S_BYTE_PERIPH_HI
                                                       : S_BYTE_PERIPH_LO)
                                        : S_BYTE_MEM;
      unique case (st.phase)
         ESC_IDLE: begin
            if (issue && n_fetch == 2'h0) begin
               next_st.illegal = 1'b1;
            end else if (issue) begin
               // Total is the weighted sum; only fetch and byte classes occur here.
               // Both factors are widened first, as three two-state fetches overflow two bits.
               next_st.total      = TOTAL_W'(n_fetch) * TOTAL_W'(S_FETCH_MEM)
                                  + (n_byte ? TOTAL_W'(n_cost) : '0);
               next_st.phase      = ESC_FETCH;
               next_st.fetch_left = n_fetch;
               next_st.byte_left  = n_byte;
               next_st.byte_cost  = n_cost;
               next_st.elapsed    = '0;
               next_st.busy       = 1'b1;
               t_load             = 1'b1;
               t_len              = S_FETCH_MEM;
            end
         end
         ESC_FETCH, ESC_DATA: begin
            // Every state of the instruction is counted, fetch and data alike.
            next_st.elapsed = st.elapsed + TOTAL_W'(1);
            if (st.phase == ESC_DATA && st.byte_cost == S_BYTE_PERIPH_HI
                && t_left == 2'h2) begin
               // The third state of a slow peripheral access stalls the pipeline.
               next_st.cpu_wait = 1'b1;
            end
            if (t_last) begin
               if (st.phase == ESC_FETCH && st.fetch_left > 2'h1) begin
                  next_st.fetch_left = st.fetch_left - 2'h1;
                  t_load             = 1'b1;
                  t_len              = S_FETCH_MEM;
               end else if (st.phase == ESC_FETCH && st.byte_left) begin
                  next_st.phase     = ESC_DATA;
                  next_st.byte_left = 1'b0;
                  t_load            = 1'b1;
                  t_len             = st.byte_cost;
               end else begin
                  // Completion is held until every state of the total has run.
                  next_st.phase = ESC_IDLE;
                  next_st.busy  = 1'b0;
                  next_st.done  = 1'b1;
               end
            end
         end
         default: begin
            // An unused phase code falls back to idle rather than hanging the pipeline.
            next_st.phase = ESC_IDLE;
            next_st.busy  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign busy         = st.busy;
   assign cpu_wait     = st.cpu_wait;
   assign done         = st.done;
   assign illegal      = st.illegal;
   assign total_states = st.total;

   // The checks below tie each timing rule except the word immediate one to the state record.
   // An accepted issue is one seen while idle with a code inside the table.
   sequence s_issue_legal;
      !st.busy && issue && esc_fetch_count(instr_code) != 2'h0;
   endsequence

   a_done_total: assert property (@(posedge clk) disable iff (!resetn)
      $rose(st.done) |-> st.elapsed == st.total)
      else $error("done raised before the total state count elapsed");

   a_fetch_pair: assert property (@(posedge clk) disable iff (!resetn)
      s_issue_legal |=> st.busy [*2])
      else $error("a fetch cycle lasted fewer than two states");

   a_periph_byte: assert property (@(posedge clk) disable iff (!resetn)
      s_issue_legal ##0 esc_byte_count(instr_code) && byte_to_periph
      |=> st.total == 4'h4 + (periph_slow ? 4'h3 : 4'h2))
      else $error("peripheral byte access cost is wrong");

   a_long_imm: assert property (@(posedge clk) disable iff (!resetn)
      s_issue_legal ##0 (instr_code == ESC_ADD_L_IMM || instr_code == ESC_AND_L_IMM)
      |=> st.total == 4'h6 ##6 st.done)
      else $error("long immediate did not take three fetch cycles");

   a_word_forms: assert property (@(posedge clk) disable iff (!resetn)
      s_issue_legal ##0 (instr_code == ESC_ADD_W_REG || instr_code == ESC_AND_W_REG)
      |=> st.total == 4'h2 ##2 st.done)
      else $error("word register form did not take one fetch cycle");

   a_long_reg: assert property (@(posedge clk) disable iff (!resetn)
      s_issue_legal ##0 instr_code == ESC_AND_L_REG |=> st.total == 4'h4)
      else $error("long register AND did not take two fetch cycles");

   a_short_form: assert property (@(posedge clk) disable iff (!resetn)
      s_issue_legal ##0 instr_code == ESC_AND_INTO_CONDITION_CODES
      |=> st.total == 4'h2)
      else $error("short form did not take one fetch cycle");

   a_bit_mem: assert property (@(posedge clk) disable iff (!resetn)
      s_issue_legal ##0 instr_code == ESC_BIT_AND_ABS8 && !byte_to_periph
      |=> ##4 st.phase == ESC_DATA)
      else $error("memory bit-AND did not access data after two fetches");

   a_branch_d8: assert property (@(posedge clk) disable iff (!resetn)
      s_issue_legal ##0 instr_code == ESC_BRANCH_D8 |=> !st.done [*4] ##1 st.done)
      else $error("short branch did not take four states");

   a_wait_slow: assert property (@(posedge clk) disable iff (!resetn)
      st.cpu_wait |-> st.phase == ESC_DATA && st.byte_cost == S_BYTE_PERIPH_HI
                      ##1 st.done)
      else $error("wait state outside the last state of a slow access");

   // A slow peripheral byte access is the only source of a wait state.
   sequence s_slow_byte;
      s_issue_legal ##0 esc_byte_count(instr_code) && byte_to_periph && periph_slow;
   endsequence

   sequence s_fast_byte;
      s_issue_legal ##0 esc_byte_count(instr_code) && !(byte_to_periph && periph_slow);
   endsequence

   a_slow_wait: assert property (@(posedge clk) disable iff (!resetn)
      s_slow_byte |=> !st.cpu_wait [*6] ##1 st.cpu_wait ##1 st.done)
      else $error("slow peripheral access did not wait exactly once");

   a_fast_nowait: assert property (@(posedge clk) disable iff (!resetn)
      s_fast_byte |=> !st.cpu_wait [*6] ##1 st.done)
      else $error("two-state byte access raised a wait state");

   a_illegal_code: assert property (@(posedge clk) disable iff (!resetn)
      !st.busy && issue && esc_fetch_count(instr_code) == 2'h0 |=> st.illegal && !st.busy)
      else $error("code outside the table was not flagged");

   a_total_hold: assert property (@(posedge clk) disable iff (!resetn)
      st.busy |=> $stable(st.total))
      else $error("total changed while an instruction was counting");

   a_done_pulse: assert property (@(posedge clk) disable iff (!resetn)
      $fell(st.busy) |-> st.done ##1 !st.done)
      else $error("completion was not a single pulse as busy fell");

   // Elapsed advances once per busy state, so it stays below the total until completion.
   a_elapsed_cap: assert property (@(posedge clk) disable iff (!resetn)
      st.busy |-> st.elapsed < st.total)
      else $error("elapsed states ran past the computed total");

   a_issue_ignored: assert property (@(posedge clk) disable iff (!resetn)
      st.busy && issue |=> !st.illegal)
      else $error("an issue while busy was decoded");

   a_wait_in_busy: assert property (@(posedge clk) disable iff (!resetn)
      st.cpu_wait |-> st.busy)
      else $error("wait state raised outside a counted instruction");
endmodule

/* dv/esc_periph_model.sv */
// Far side of the state counter: picks the target of a byte data access.
// Assumes module_sel comes from the bench; 0 is on-chip memory, 1 to 3 peripherals.
`timescale 1ns/1ns
module esc_periph_model (
   input  wire logic [1:0] module_sel,
   output logic            byte_to_periph,
   output logic            periph_slow
);
   // The speed is a fixed property of each peripheral, so it is decoded, never toggled.
   assign byte_to_periph = (module_sel != 2'h0);
   assign periph_slow    = module_sel[1];
endmodule

/* dv/cpu_execution_state_counter_tb.sv */
// Testbench for the execution state counter: timing table first, then edge cases.
// Assumes esc_pkg, the design files and the peripheral model are compiled before it.
`timescale 1ns/1ns
module cpu_execution_state_counter_tb
   import esc_pkg::*;
();
   typedef struct packed {
      logic [INSTR_W-1:0] code;
      logic [1:0]         sel;
      logic [TOTAL_W-1:0] tot;
      logic               w;
   } esc_row_t;
   logic               clk;
   logic               resetn;
   logic               issue;
   logic [INSTR_W-1:0] instr_code;
   logic [1:0]         module_sel;
   logic               byte_to_periph;
   logic               periph_slow;
   logic               busy;
   logic               cpu_wait;
   logic               done;
   logic               illegal;
   logic [TOTAL_W-1:0] total_states;
   int                 n_errors;
   int                 num_checks;
   int                 ticks = 0;
   esc_row_t           rows [24];

   esc_state_counter DUT (.clk(clk), .resetn(resetn), .issue(issue), .instr_code(instr_code),
      .byte_to_periph(byte_to_periph), .periph_slow(periph_slow), .busy(busy),
      .cpu_wait(cpu_wait), .done(done), .illegal(illegal), .total_states(total_states));
   esc_periph_model PM (.module_sel(module_sel), .byte_to_periph(byte_to_periph),
      .periph_slow(periph_slow));

   task automatic test_done();
      if (n_errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk_bit(input string nm, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %b seen %b", nm, exp, got);
      end
   endtask

   task automatic chk_tot(input string nm, input logic [TOTAL_W-1:0] exp,
                          input logic [TOTAL_W-1:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %0d seen %0d", nm, exp, got);
      end
   endtask

   task automatic chk_cnt(input string nm, input int exp, input int got);
      num_checks++;
      if (got != exp) begin
         n_errors++;
         $display("mismatch %s expected %0d seen %0d", nm, exp, got);
      end
   endtask

   // Entered 1 ns after an edge, so a call straight after another is back to back.
   // With poke set, a second issue of a longer instruction is offered while busy.
   task automatic run(input esc_row_t r, input logic poke);
      int n;
      int w;
      n = 0;
      w = 0;
      issue = 1'b1;
      instr_code = r.code;
      module_sel = r.sel;
      @(posedge clk);
      #1;
      issue = poke;
      if (poke) instr_code = 5'h0d;
      chk_tot("total_states", r.tot, total_states);
      while (busy === 1'b1 && n < 20) begin
         if (n == 1) issue = 1'b0;
         if (cpu_wait === 1'b1) w++;
         n++;
         @(posedge clk);
         #1;
      end
      chk_cnt("busy states", r.tot, n);
      chk_cnt("wait states", r.w, w);
      chk_bit("done", 1'b1, done);
      chk_tot("total held", r.tot, total_states);
   endtask

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      ticks <= ticks + 1;
      if (ticks == 1000) begin
         n_errors++;
         test_done();
      end
   end

   initial begin
      resetn = 1'b0;
      issue = 1'b0;
      instr_code = 5'h00;
      module_sel = 2'h0;
      n_errors = 0;
      num_checks = 0;
      // Code, target, expected states, expected wait states.
      rows = '{'{5'h00, 2'h0, 4'h2, 1'b0}, '{5'h01, 2'h0, 4'h2, 1'b0},
               '{5'h02, 2'h0, 4'h4, 1'b0}, '{5'h03, 2'h0, 4'h2, 1'b0},
               '{5'h04, 2'h3, 4'h6, 1'b0}, '{5'h05, 2'h0, 4'h2, 1'b0},
               '{5'h06, 2'h0, 4'h2, 1'b0}, '{5'h07, 2'h0, 4'h2, 1'b0},
               '{5'h08, 2'h0, 4'h2, 1'b0}, '{5'h09, 2'h0, 4'h2, 1'b0},
               '{5'h0a, 2'h0, 4'h2, 1'b0}, '{5'h0b, 2'h0, 4'h4, 1'b0},
               '{5'h0c, 2'h0, 4'h2, 1'b0}, '{5'h0d, 2'h0, 4'h6, 1'b0},
               '{5'h0e, 2'h0, 4'h4, 1'b0}, '{5'h0f, 2'h0, 4'h2, 1'b0},
               '{5'h10, 2'h0, 4'h2, 1'b0}, '{5'h11, 2'h2, 4'h7, 1'b1},
               '{5'h12, 2'h1, 4'h6, 1'b0}, '{5'h13, 2'h2, 4'h4, 1'b0},
               '{5'h11, 2'h0, 4'h6, 1'b0}, '{5'h11, 2'h1, 4'h6, 1'b0},
               '{5'h12, 2'h0, 4'h6, 1'b0}, '{5'h12, 2'h3, 4'h7, 1'b1}};
      repeat (16) @(posedge clk);
      #1;
      chk_bit("busy in reset", 1'b0, busy);
      chk_bit("done in reset", 1'b0, done);
      chk_bit("illegal in reset", 1'b0, illegal);
      resetn = 1'b1;
      @(posedge clk);
      #1;
      chk_bit("done after reset", 1'b0, done);
      foreach (rows[i]) run(rows[i], 1'b0);
      run(rows[19], 1'b1);
      issue = 1'b1;
      instr_code = 5'h14;
      @(posedge clk);
      #1;
      issue = 1'b0;
      chk_bit("illegal", 1'b1, illegal);
      chk_bit("busy on illegal", 1'b0, busy);
      @(posedge clk);
      #1;
      chk_bit("illegal pulse", 1'b0, illegal);
      run(rows[17], 1'b0);
      // A reset in the middle of a count must drop busy without a clock edge.
      issue = 1'b1;
      instr_code = 5'h04;
      @(posedge clk);
      #1;
      issue = 1'b0;
      @(posedge clk);
      #1;
      resetn = 1'b0;
      #1;
      chk_bit("busy after reset", 1'b0, busy);
      chk_tot("total after reset", 4'h0, total_states);
      chk_bit("wait after reset", 1'b0, cpu_wait);
      @(posedge clk);
      #1;
      resetn = 1'b1;
      run(rows[19], 1'b0);
      test_done();
   end
endmodule
